/* src/atc_top.sv */
`timescale 1ns/1ps
module atc_top #(
	parameter int BLOCK_WORDS = atc_pkg::BLOCK_WORDS,
	parameter bit FLUSH_SUPPORTED = 1'b1,
	parameter bit IS_MASTER = 1'b1
)(
	input wire logic clk,
	input wire logic nrst,
	input wire logic [4:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire atc_pkg::atc_pwr_e pwr_mode,
	input wire logic slave_diag_pass,
	output logic trim_valid,
	input wire logic trim_ready,
	output logic [31:0] trim_data,
	output logic job_start,
	output atc_pkg::atc_job_e job_kind,
	input wire logic job_done,
	input wire atc_pkg::atc_result_s job_result,
	output logic frame_valid,
	input wire logic frame_ready,
	output atc_pkg::atc_frame_s frame
);
	// word counter is eight bits wide
	if (BLOCK_WORDS < 1 || BLOCK_WORDS > 255)
	begin : g_bad_words
		$error("BLOCK_WORDS out of range");
	end
	////////////////////////////////////////////////////////////////////////
	// reset release
	logic rst_s1;
	logic rst_n;
	// two stages so release is clean against clk
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			rst_s1 <= 1'b0;
			rst_n <= 1'b0;
		end
		else
		begin
			rst_s1 <= 1'b1;
			rst_n <= rst_s1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// slave diagnostic pin, three stages
	logic [2:0] pdiag_sync;
	logic slave_pass;
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			pdiag_sync <= 3'h0;
		else
			pdiag_sync <= {pdiag_sync[1:0], slave_diag_pass};
	end
	// accept a change only when stages two and three agree
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			slave_pass <= 1'b0;
		else if (pdiag_sync[1] == pdiag_sync[2])
			slave_pass <= pdiag_sync[2];
	end

	////////////////////////////////////////////////////////////////////////
	// bus slave handshake
	atc_pkg::atc_state_e state;
	logic ack;
	logic pend_trim;
	logic req;
	logic data_wr;
	logic take;
	logic [7:0] feat;
	logic [15:0] scount;
	logic [7:0] devhead;
	logic [7:0] status;
	logic [7:0] error;
	logic [7:0] wcount;
	assign req = avs_read | avs_write;
	assign data_wr = avs_write && avs_address == atc_pkg::OFF_DATA;
	assign avs_waitrequest = req & ~ack;
	assign take = req & ack;
	// a trim word is offered only while the block is open
	assign trim_valid = pend_trim & ~ack;
	// every access waits one cycle; trim words wait for the back end
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ack <= 1'b0;
			pend_trim <= 1'b0;
		end
		else if (ack)
		begin
			ack <= 1'b0;
			pend_trim <= 1'b0;
		end
		else if (pend_trim)
			ack <= trim_ready;
		else if (req)
		begin
			if (data_wr && state == atc_pkg::S_TRIM_XFER && wcount < 8'(BLOCK_WORDS))
				pend_trim <= 1'b1;
			else
				ack <= 1'b1;
		end
	end
	// read data and trim word captured on the first request cycle
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			avs_readdata <= 32'h0;
			trim_data <= 32'h0;
		end
		else if (req && !ack && !pend_trim)
		begin
			trim_data <= avs_writedata;
			case (avs_address)
				atc_pkg::OFF_ERR_FEAT: avs_readdata <= {24'h0, error};
				atc_pkg::OFF_SCOUNT: avs_readdata <= {16'h0, scount};
				atc_pkg::OFF_DEVHEAD: avs_readdata <= {24'h0, devhead};
				atc_pkg::OFF_STAT_CMD: avs_readdata <= {24'h0, status};
				default: avs_readdata <= 32'h0;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// task-file writes
	logic host_wr;
	logic lane0;
	logic cmd_wr;
	logic busy;
	assign host_wr = take & avs_write;
	assign lane0 = avs_byteenable[0];
	assign busy = state != atc_pkg::S_IDLE;
	assign cmd_wr = host_wr && lane0 && avs_address == atc_pkg::OFF_STAT_CMD && !busy;
	// parameters are frozen while a command runs
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			feat <= atc_pkg::RST_BYTE;
			devhead <= atc_pkg::RST_BYTE;
		end
		else if (host_wr && lane0 && !busy)
		begin
			if (avs_address == atc_pkg::OFF_ERR_FEAT)
				feat <= avs_writedata[7:0];
			if (avs_address == atc_pkg::OFF_DEVHEAD)
				devhead <= avs_writedata[7:0];
		end
	end
	////////////////////////////////////////////////////////////////////////
	// command decode
	logic is_pmq;
	logic dsm_ok;
	assign is_pmq = avs_writedata[7:0] == atc_pkg::CMD_PMQ_A || avs_writedata[7:0] == atc_pkg::CMD_PMQ_B;
	// a zero count is reserved and more than one block is refused
	assign dsm_ok = feat[atc_pkg::FEAT_TRIM] && scount == 16'h0001;

	////////////////////////////////////////////////////////////////////////
	// command sequencer
	logic fin;
	logic fin_err;
	logic fin_abrt;
	logic [7:0] fin_code;
	logic fin_code_en;
	logic pmq_standby;
	logic block_done;
	assign pmq_standby = pwr_mode != atc_pkg::PWR_IDLE;
	assign block_done = take && pend_trim && wcount == 8'(BLOCK_WORDS - 1);
	always_comb
	begin
		fin = 1'b0;
		fin_err = 1'b0;
		fin_abrt = 1'b0;
		fin_code = 8'h00;
		fin_code_en = 1'b0;
		if (cmd_wr && avs_writedata[7:0] == atc_pkg::CMD_DSM && !dsm_ok)
		begin
			fin = 1'b1;
			fin_err = 1'b1;
			fin_abrt = 1'b1;
		end
		else if (cmd_wr && avs_writedata[7:0] == atc_pkg::CMD_FLUSH && !FLUSH_SUPPORTED)
		begin
			fin = 1'b1;
			fin_err = 1'b1;
			fin_abrt = 1'b1;
		end
		else if (cmd_wr && !is_pmq && avs_writedata[7:0] != atc_pkg::CMD_DSM
			&& avs_writedata[7:0] != atc_pkg::CMD_DIAG && avs_writedata[7:0] != atc_pkg::CMD_FLUSH)
		begin
			// codes outside this block are aborted
			fin = 1'b1;
			fin_err = 1'b1;
			fin_abrt = 1'b1;
		end
		else if (state == atc_pkg::S_PMQ)
			fin = 1'b1;
		else if (state == atc_pkg::S_JOB_RUN && job_done)
		begin
			fin = 1'b1;
			if (job_kind == atc_pkg::JOB_DIAG)
			begin
				// diagnostic reports through its code, not through abort
				fin_code_en = 1'b1;
				fin_code = job_result.code;
				if (IS_MASTER && !slave_pass)
					fin_code[atc_pkg::ER_SLAVE_FAIL] = 1'b1;
			end
			else if (job_result.fail)
			begin
				fin_err = 1'b1;
				fin_abrt = 1'b1;
			end
		end
	end
	// states of the command in flight
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			state <= atc_pkg::S_IDLE;
		else
		begin
			case (state)
				atc_pkg::S_IDLE:
				begin
					if (fin)
						state <= atc_pkg::S_FRAME;
					else if (cmd_wr && is_pmq)
						state <= atc_pkg::S_PMQ;
					else if (cmd_wr && avs_writedata[7:0] == atc_pkg::CMD_DSM)
						state <= atc_pkg::S_TRIM_XFER;
					else if (cmd_wr)
						state <= atc_pkg::S_JOB_RUN;
				end
				atc_pkg::S_PMQ: state <= atc_pkg::S_FRAME;
				atc_pkg::S_TRIM_XFER:
				begin
					if (block_done)
						state <= atc_pkg::S_JOB_RUN;
				end
				atc_pkg::S_JOB_RUN:
				begin
					if (fin)
						state <= atc_pkg::S_FRAME;
				end
				atc_pkg::S_FRAME:
				begin
					if (frame_ready)
						state <= atc_pkg::S_IDLE;
				end
				default: state <= atc_pkg::S_IDLE;
			endcase
		end
	end
	// back-end job request, one-cycle start pulse
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			job_start <= 1'b0;
			job_kind <= atc_pkg::JOB_NONE;
		end
		else
		begin
			job_start <= 1'b0;
			if (state == atc_pkg::S_IDLE && cmd_wr && !fin && avs_writedata[7:0] == atc_pkg::CMD_DIAG)
			begin
				// drive select is not looked at here
				job_start <= 1'b1;
				job_kind <= atc_pkg::JOB_DIAG;
			end
			else if (state == atc_pkg::S_IDLE && cmd_wr && !fin && avs_writedata[7:0] == atc_pkg::CMD_FLUSH)
			begin
				job_start <= 1'b1;
				job_kind <= atc_pkg::JOB_FLUSH;
			end
			else if (block_done)
			begin
				job_start <= 1'b1;
				job_kind <= atc_pkg::JOB_TRIM;
			end
		end
	end
	// words of the trim block taken so far
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			wcount <= 8'h00;
		else if (state == atc_pkg::S_IDLE)
			wcount <= 8'h00;
		else if (take && pend_trim)
			wcount <= wcount + 8'h01;
	end
	////////////////////////////////////////////////////////////////////////
	// sector count: host writes upper byte then lower byte
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			scount <= atc_pkg::RST_SCOUNT;
		else if (state == atc_pkg::S_PMQ)
			scount <= pmq_standby ? {8'h00, atc_pkg::PMQ_STANDBY} : {8'h00, atc_pkg::PMQ_IDLE};
		else if (host_wr && lane0 && !busy && avs_address == atc_pkg::OFF_SCOUNT)
			scount <= {scount[7:0], avs_writedata[7:0]};
	end
	////////////////////////////////////////////////////////////////////////
	// status and error registers
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			status <= atc_pkg::RST_STATUS;
		else if (cmd_wr)
		begin
			status <= 8'h00;
			status[atc_pkg::ST_BSY] <= ~fin && avs_writedata[7:0] != atc_pkg::CMD_DSM;
			status[atc_pkg::ST_RDY] <= fin;
			status[atc_pkg::ST_DSC] <= fin;
			status[atc_pkg::ST_ERR] <= fin_err;
			status[atc_pkg::ST_DRQ] <= ~fin && avs_writedata[7:0] == atc_pkg::CMD_DSM;
		end
		else if (block_done)
		begin
			status[atc_pkg::ST_DRQ] <= 1'b0;
			status[atc_pkg::ST_BSY] <= 1'b1;
		end
		else if (fin)
		begin
			// ready and seek complete once the back end job or the power query is done
			status[atc_pkg::ST_BSY] <= 1'b0;
			status[atc_pkg::ST_RDY] <= 1'b1;
			status[atc_pkg::ST_DSC] <= 1'b1;
			status[atc_pkg::ST_ERR] <= fin_err;
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			error <= atc_pkg::RST_ERROR;
		else if (fin && fin_code_en)
			error <= fin_code;
		else if (fin)
		begin
			error <= 8'h00;
			error[atc_pkg::ER_ABRT] <= fin_abrt;
		end
	end
	////////////////////////////////////////////////////////////////////////
	// register frame to transport, held until taken
	assign frame_valid = state == atc_pkg::S_FRAME;
	always_comb
	begin
		frame.status = status;
		frame.error = error;
		frame.scount = scount;
		frame.irq = 1'b1;
	end
endmodule : atc_top

/* src/atc_pkg.sv */
// What this block does
// - two command codes both mean power query
// - standby-related query loads zero into count
// - idle query loads all ones into count
// - decode trim command code, accept trim hints
// - count gives blocks; zero count is reserved
// - only trim feature bit supported
// - at most one block per trim command
// - diagnostic code runs internal self tests
// - diagnostic ignores the drive select bit
// - master reports combined status of both
// - diagnostic result code goes to error register
// - flush writes pending cache to media
// - flush done shows ready and seek complete
// - unsupported flush ends command aborted
// - finished command sends register frame, interrupt
package atc_pkg;
	// register byte addresses
	localparam logic [4:0] OFF_DATA = 5'h00;
	localparam logic [4:0] OFF_ERR_FEAT = 5'h04;
	localparam logic [4:0] OFF_SCOUNT = 5'h08;
	localparam logic [4:0] OFF_DEVHEAD = 5'h0c;
	localparam logic [4:0] OFF_STAT_CMD = 5'h10;
	// command codes
	localparam logic [7:0] CMD_PMQ_A = 8'h98;
	localparam logic [7:0] CMD_PMQ_B = 8'he5;
	localparam logic [7:0] CMD_DSM = 8'h06;
	localparam logic [7:0] CMD_DIAG = 8'h90;
	localparam logic [7:0] CMD_FLUSH = 8'he7;
	// status bit positions
	localparam int ST_BSY = 7;
	localparam int ST_RDY = 6;
	localparam int ST_DSC = 4;
	localparam int ST_DRQ = 3;
	localparam int ST_ERR = 0;
	// error bit positions and codes
	localparam int ER_ABRT = 2;
	localparam int ER_SLAVE_FAIL = 7;
	localparam int FEAT_TRIM = 0;
	localparam logic [7:0] DIAG_OK = 8'h01;
	localparam logic [7:0] PMQ_STANDBY = 8'h00;
	localparam logic [7:0] PMQ_IDLE = 8'hff;
	// reset values
	localparam logic [7:0] RST_STATUS = 8'h50;
	localparam logic [7:0] RST_ERROR = 8'h01;
	localparam logic [15:0] RST_SCOUNT = 16'h0001;
	localparam logic [7:0] RST_BYTE = 8'h00;
	// one 512-byte block in 32-bit words
	localparam int BLOCK_WORDS = 128;

	typedef enum logic [1:0]
	{
		PWR_IDLE = 2'b00,
		PWR_STANDBY = 2'b01,
		PWR_ENTERING = 2'b10,
		PWR_EXITING = 2'b11
	} atc_pwr_e;

	typedef enum logic [1:0]
	{
		JOB_DIAG = 2'b00,
		JOB_FLUSH = 2'b01,
		JOB_TRIM = 2'b10,
		JOB_NONE = 2'b11
	} atc_job_e;

	typedef enum logic [2:0]
	{
		S_IDLE = 3'b000,
		S_PMQ = 3'b001,
		S_TRIM_XFER = 3'b010,
		S_JOB_RUN = 3'b011,
		S_FRAME = 3'b100
	} atc_state_e;

	// result handed to the transport layer
	typedef struct packed
	{
		logic [7:0] status;
		logic [7:0] error;
		logic [15:0] scount;
		logic irq;
	} atc_frame_s;

	// answer from the back end
	typedef struct packed
	{
		logic fail;
		logic [7:0] code;
	} atc_result_s;
endpackage : atc_pkg

/* dv/atc_chk.sv */
`timescale 1ns/1ps
module atc_chk #(
	parameter bit FLUSH_SUPPORTED = 1'h1
)(
	input wire logic clk,
	input wire logic nrst,
	input wire logic [4:0] avs_address,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic avs_waitrequest,
	input wire atc_pkg::atc_pwr_e pwr_mode,
	input wire logic job_start,
	input wire atc_pkg::atc_job_e job_kind,
	input wire logic job_done,
	input wire atc_pkg::atc_result_s job_result,
	input wire logic frame_valid,
	input wire logic frame_ready,
	input wire atc_pkg::atc_frame_s frame
);
	logic busy;
	logic run;
	logic take;
	logic [7:0] c;
	////////////////////////////////////////////////////////////
	// command accepted only while none is open; busy writes are dropped
	assign take = avs_write && !avs_waitrequest && avs_address == atc_pkg::OFF_STAT_CMD && !busy;
	assign c = avs_writedata[7:0];
	// open command ends at frame handover
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			busy <= 1'h0;
		else if (take || (frame_valid && frame_ready))
			busy <= take;
	end
	// back end job outstanding
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			run <= 1'h0;
		else if (job_start || job_done)
			run <= job_start;
	end
	////////////////////////////////////////////////////////////
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	property p_pmq_idle;
		take && (c == atc_pkg::CMD_PMQ_A || c == atc_pkg::CMD_PMQ_B) && pwr_mode == atc_pkg::PWR_IDLE
			|-> ##2 frame_valid && frame.scount[7:0] == 8'hff;
	endproperty
	a_pmq_idle: assert property (p_pmq_idle)
		else $error("idle query count wrong");
	property p_pmq_stby;
		take && (c == atc_pkg::CMD_PMQ_A || c == atc_pkg::CMD_PMQ_B) && pwr_mode != atc_pkg::PWR_IDLE
			|-> ##2 frame_valid && frame.scount[7:0] == 8'h00;
	endproperty
	a_pmq_stby: assert property (p_pmq_stby)
		else $error("standby query count wrong");
	property p_diag_go;
		take && c == atc_pkg::CMD_DIAG |=> job_start && job_kind == atc_pkg::JOB_DIAG;
	endproperty
	a_diag_go: assert property (p_diag_go)
		else $error("diagnostic not started");
	property p_flush_go;
		take && c == atc_pkg::CMD_FLUSH && FLUSH_SUPPORTED |=> job_start && job_kind == atc_pkg::JOB_FLUSH;
	endproperty
	a_flush_go: assert property (p_flush_go)
		else $error("flush not started");
	property p_hold;
		run && !job_done |-> !frame_valid;
	endproperty
	a_hold: assert property (p_hold)
		else $error("frame before job done");
	property p_done;
		run && job_done |=> frame_valid && frame.irq;
	endproperty
	a_done: assert property (p_done)
		else $error("no frame after job done");
	property p_stand;
		frame_valid && !frame_ready |=> frame_valid && $stable(frame);
	endproperty
	a_stand: assert property (p_stand)
		else $error("frame dropped or changed");
	property p_diag_res;
		$rose(frame_valid) && $past(run) && job_kind == atc_pkg::JOB_DIAG
			|-> (frame.error & 8'h7f) == ($past(job_result.code) & 8'h7f) && !frame.status[atc_pkg::ST_ERR];
	endproperty
	a_diag_res: assert property (p_diag_res)
		else $error("diagnostic code wrong");
	property p_flush_res;
		$rose(frame_valid) && $past(run) && job_kind == atc_pkg::JOB_FLUSH
			|-> frame.status == {7'h28, $past(job_result.fail)};
	endproperty
	a_flush_res: assert property (p_flush_res)
		else $error("flush status wrong");
endmodule : atc_chk
bind atc_top atc_chk #(.FLUSH_SUPPORTED(FLUSH_SUPPORTED)) i_chk (.clk(clk), .nrst(nrst),
	.avs_address(avs_address), .avs_write(avs_write), .avs_writedata(avs_writedata),
	.avs_waitrequest(avs_waitrequest), .pwr_mode(pwr_mode), .job_start(job_start), .job_kind(job_kind),
	.job_done(job_done), .job_result(job_result), .frame_valid(frame_valid), .frame_ready(frame_ready),
	.frame(frame));

/* dv/atc_be_model.sv */
`timescale 1ns/1ps
module atc_be_model (
	input wire logic clk,
	input wire logic nrst,
	input wire logic trim_valid,
	input wire logic [31:0] trim_data,
	output logic trim_ready,
	input wire logic job_start,
	output logic job_done,
	output atc_pkg::atc_result_s job_result,
	input wire logic frame_valid,
	output logic frame_ready,
	input wire logic [3:0] lat,
	input wire atc_pkg::atc_result_s res,
	output logic [31:0] last_word
);
	logic [3:0] cnt;
	logic busy;
	////////////////////////////////////////////////////////////
	// stall every other cycle so the data phase must wait; transport takes frames one cycle late
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			trim_ready <= 1'h0;
			frame_ready <= 1'h0;
		end
		else
		begin
			trim_ready <= !trim_ready && trim_valid;
			frame_ready <= frame_valid && !frame_ready;
		end
	end
	// last accepted trim word
	always_ff @(posedge clk)
	begin
		if (trim_valid && trim_ready)
			last_word <= trim_data;
	end
	// job ends lat+2 cycles after job_start; result lines toggle outside the done pulse
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			busy <= 1'h0;
			cnt <= 4'h0;
			job_done <= 1'h0;
			job_result <= '0;
		end
		else
		begin
			job_done <= 1'h0;
			job_result <= ~job_result;
			if (job_start)
			begin
				busy <= 1'h1;
				cnt <= lat;
			end
			else if (busy && cnt != 4'h0)
				cnt <= cnt - 4'h1;
			else if (busy)
			begin
				busy <= 1'h0;
				job_done <= 1'h1;
				job_result <= res;
			end
		end
	end
endmodule : atc_be_model

/* dv/testbench.sv */
`timescale 1ns/1ps
module testbench;
	logic clk;
	logic nrst;
	logic [4:0] avs_address;
	logic avs_read;
	logic avs_write;
	logic [31:0] avs_writedata;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	atc_pkg::atc_pwr_e pwr_mode;
	logic slave_diag_pass;
	logic trim_valid;
	logic trim_ready;
	logic [31:0] trim_data;
	logic job_start;
	atc_pkg::atc_job_e job_kind;
	logic job_done;
	atc_pkg::atc_result_s job_result;
	logic frame_valid;
	logic frame_ready;
	atc_pkg::atc_frame_s frame;
	logic [3:0] lat;
	atc_pkg::atc_result_s res;
	logic [31:0] last_word;
	logic [31:0] q;
	atc_pkg::atc_frame_s fr;
	int fails;
	int total_checks;
	int cyc = 0;
	logic [7:0] codes [3] = '{8'h01, 8'h02, 8'h05};
	logic [23:0] setup [5] = '{24'h000001, 24'h010000, 24'h010002, 24'h020001, 24'h010001};
	////////////////////////////////////////////////////////////
	// two words per trim block keeps the run short
	atc_top #(.BLOCK_WORDS(2)) i_dut (.clk(clk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .pwr_mode(pwr_mode), .slave_diag_pass(slave_diag_pass),
		.trim_valid(trim_valid), .trim_ready(trim_ready), .trim_data(trim_data), .job_start(job_start),
		.job_kind(job_kind), .job_done(job_done), .job_result(job_result), .frame_valid(frame_valid),
		.frame_ready(frame_ready), .frame(frame));
	atc_be_model i_be (.clk(clk), .nrst(nrst), .trim_valid(trim_valid), .trim_data(trim_data),
		.trim_ready(trim_ready), .job_start(job_start), .job_done(job_done), .job_result(job_result),
		.frame_valid(frame_valid), .frame_ready(frame_ready), .lat(lat), .res(res), .last_word(last_word));
	// free running clock
	initial
	begin
		clk = 1'h0;
		forever #2.5 clk = ~clk;
	end
	// hang guard, far above the few hundred cycles needed
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			fails++;
			tally_and_finish();
		end
	end
	////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
		total_checks++;
		if (seen !== exp)
		begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	// one access; held until the rising edge that sees waitrequest low, read data taken there
	task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
		@(posedge clk);
		avs_write <= w;
		avs_read <= !w;
		avs_address <= a;
		avs_writedata <= d;
		do @(posedge clk); while (avs_waitrequest !== 1'h0);
		q = avs_readdata;
		avs_write <= 1'h0;
		avs_read <= 1'h0;
	endtask : bus
	task automatic wait_frame;
		do @(negedge clk); while (frame_valid !== 1'h1);
		fr = frame;
		chk(fr.irq, 1'h1, "frame irq");
		@(posedge clk);
	endtask : wait_frame
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : tally_and_finish
	////////////////////////////////////////////////////////////
	initial
	begin
		{nrst, avs_address, avs_read, avs_write, avs_writedata, slave_diag_pass, lat} = '0;
		pwr_mode = atc_pkg::PWR_IDLE;
		res = '0;
		lat = 4'h3;
		fails = 0;
		total_checks = 0;
		repeat (8) @(posedge clk);
		nrst <= 1'h1;
		repeat (4) @(posedge clk);
		// both query codes in every power state
		for (int i = 0; i < 8; i++)
		begin
			pwr_mode <= atc_pkg::atc_pwr_e'(i[1:0]);
			bus(1'h1, atc_pkg::OFF_STAT_CMD, i[2] ? 32'he5 : 32'h98);
			wait_frame();
			chk(fr.scount[7:0], i[1:0] == 2'h0 ? 8'hff : 8'h00, "query count");
			chk(fr.status, 8'h50, "query status");
		end
		$display("test power query done");
		// drive bit toggled; last pass has the other device failing
		for (int i = 0; i < 4; i++)
		begin
			bus(1'h1, atc_pkg::OFF_DEVHEAD, {27'h0, i[0], 4'h0});
			res <= '{fail: 1'h0, code: i < 3 ? codes[i] : 8'h01};
			slave_diag_pass <= i < 3;
			repeat (6) @(posedge clk);
			bus(1'h1, atc_pkg::OFF_STAT_CMD, 32'h90);
			wait_frame();
			chk(fr.error, i < 3 ? codes[i] : 8'h81, "diag error");
		end
		$display("test diagnostic done");
		// flush good then failing
		for (int i = 0; i < 2; i++)
		begin
			res <= '{fail: i[0], code: 8'h00};
			bus(1'h1, atc_pkg::OFF_STAT_CMD, 32'he7);
			wait_frame();
			chk(fr.status, {7'h28, i[0]}, "flush status");
		end
		$display("test flush done");
		res <= '0; // trim job must succeed; last flush left a failure here
		// bad trim setups abort; last one is legal
		for (int i = 0; i < 5; i++)
		begin
			bus(1'h1, atc_pkg::OFF_ERR_FEAT, {24'h0, setup[i][23:16]});
			bus(1'h1, atc_pkg::OFF_SCOUNT, {24'h0, setup[i][15:8]});
			bus(1'h1, atc_pkg::OFF_SCOUNT, {24'h0, setup[i][7:0]});
			bus(1'h1, atc_pkg::OFF_STAT_CMD, 32'h06);
			if (i == 4)
			begin
				bus(1'h0, atc_pkg::OFF_STAT_CMD, 32'h0);
				chk(q[7:0] & 8'h88, 8'h08, "trim data request");
				bus(1'h1, atc_pkg::OFF_DATA, 32'h11112222);
				bus(1'h1, atc_pkg::OFF_DATA, 32'hcafe0042);
			end
			wait_frame();
			chk(fr.status, i == 4 ? 8'h50 : 8'h51, "trim status");
			chk(fr.error[2], i != 4, "trim abort bit");
		end
		chk(job_kind, atc_pkg::JOB_TRIM, "trim job");
		chk(last_word, 32'hcafe0042, "trim word");
		$display("test trim done");
		tally_and_finish();
	end
endmodule : testbench
